// ---- dtmg_listener.sv ----
// Far-side listener model: speech circuit and loudspeaker on the tone pins
`timescale 1ns/10ps
`default_nettype none
module dtmg_listener (
   input wire logic aclk,
   input wire logic clear,
   input wire logic [5:0] row_sample,
   input wire logic [5:0] col_sample,
   input wire logic pacifier,
   output logic [31:0] low_len,
   output logic [31:0] low_total,
   output logic [31:0] row_moves,
   output logic [31:0] col_moves,
   output logic [31:0] col_odd,
   output logic [5:0] col_peak
);
   logic [31:0] run; // Length of the current low stretch
   // Times each low stretch of the pacifier and sums the tone activity;
   // a stretch cut by clear is dropped so stale timing never leaks in
   always @(posedge aclk) begin
      if (clear) begin
         run <= '0;
         low_len <= '0;
         low_total <= '0;
         row_moves <= '0;
         col_moves <= '0;
         col_odd <= '0;
         col_peak <= '0;
      end else begin
         if (!pacifier) begin
            run <= run + 1;
            low_total <= low_total + 1;
         end else if (run != 0) begin
            low_len <= run;
            run <= '0;
         end
         if (row_sample != 6'h20) row_moves <= row_moves + 1;
         if (col_sample != 6'h20) col_moves <= col_moves + 1;
         // Square content may only be the midpoint or the floor code
         if (col_sample != 6'h20 && col_sample != 6'h00) begin
            col_odd <= col_odd + 1;
         end
         if (col_sample > col_peak) col_peak <= col_sample;
      end
   end
endmodule : dtmg_listener
`default_nettype wire

// ---- dtmg_pkg.sv ----
// Shared constants, types and tables of the dual tone melody generator
`default_nettype none
package dtmg_pkg;

   // Clock figures: system clock and the half-rate tone base clock
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int TONE_CLK_HZ = 1_789_773;
   // Rounded so the tone base stays as near the nominal rate as possible
   localparam int PRESCALE_CNT = (SYS_CLK_HZ + TONE_CLK_HZ / 2) / TONE_CLK_HZ;
   localparam int PRE_W = $clog2(PRESCALE_CNT);

   // Register indices and their byte addresses on the bus
   localparam logic [5:0] ROW_SEL_IDX = 6'h0D;
   localparam logic [5:0] COL_SEL_IDX = 6'h0E;
   localparam logic [5:0] CTRL_IDX = 6'h0F;
   localparam logic [5:0] STATUS_IDX = 6'h10;
   localparam logic [7:0] ROW_SEL_ADDR = {ROW_SEL_IDX, 2'b00};
   localparam logic [7:0] COL_SEL_ADDR = {COL_SEL_IDX, 2'b00};
   localparam logic [7:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
   localparam logic [7:0] STATUS_ADDR = {STATUS_IDX, 2'b00};

   // Control field positions, reset value and writable mask
   localparam int MODE_HI_BIT = 7;
   localparam int MODE_LO_BIT = 6;
   localparam int ROW_EN_BIT = 5;
   localparam int COL_EN_BIT = 4;
   localparam int OUT_EN_BIT = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'hF8;
   localparam logic [4:0] SEL_RESET = 5'h00;

   // Wave modes held in the two-bit mode field
   localparam logic [1:0] MODE_SINE = 2'b00;
   localparam logic [1:0] MODE_SQUARE1 = 2'b01;
   localparam logic [1:0] MODE_SQUARE2 = 2'b10;
   localparam logic [1:0] MODE_SQUARE3 = 2'b11;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Staircase table geometry
   localparam int STEPS = 28;
   localparam int SAMPLE_W = 6;
   localparam int SCAN_W = 5;
   localparam int DIV_W = 7;
   localparam logic [SAMPLE_W-1:0] SINE_MID = 6'h20;
   localparam logic [SCAN_W-1:0] SCAN_LAST = 5'(STEPS - 1);
   localparam int ROW = 0;
   localparam int COL = 1;

   // Divider and scanner of one path
   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic [SCAN_W-1:0] scan;
   } dtmg_path_t;

   // Divide ratio per code: base clock / (ratio * 28) gives the tone
   function automatic logic [DIV_W-1:0] tone_ratio(input logic [4:0] code);
      logic [DIV_W-1:0] r;
      r = 7'd92;
      unique case (code)
         5'h00: r = 7'd92;
         5'h01: r = 7'd83;
         5'h02: r = 7'd75;
         5'h03: r = 7'd68;
         5'h04: r = 7'd103;
         5'h05: r = 7'd97;
         5'h06: r = 7'd92;
         5'h07: r = 7'd86;
         5'h08: r = 7'd82;
         5'h09: r = 7'd77;
         5'h0A: r = 7'd73;
         5'h0B: r = 7'd69;
         5'h0C: r = 7'd65;
         5'h0D: r = 7'd61;
         5'h0E: r = 7'd58;
         5'h0F: r = 7'd54;
         5'h10: r = 7'd53;
         5'h11: r = 7'd48;
         5'h12: r = 7'd43;
         5'h13: r = 7'd39;
         5'h14: r = 7'd51;
         5'h15: r = 7'd48;
         5'h16: r = 7'd46;
         5'h17: r = 7'd43;
         5'h18: r = 7'd41;
         5'h19: r = 7'd38;
         5'h1A: r = 7'd36;
         5'h1B: r = 7'd34;
         5'h1C: r = 7'd32;
         5'h1D: r = 7'd31;
         5'h1E: r = 7'd29;
         5'h1F: r = 7'd27;
      endcase
      return r;
   endfunction : tone_ratio

   // Sine staircase, entry 0 is the dc midpoint
   function automatic logic [SAMPLE_W-1:0] sine_step(input logic [4:0] k);
      logic [SAMPLE_W-1:0] v;
      v = SINE_MID;
      case (k)
         5'd1, 5'd13: v = 6'h27;
         5'd2, 5'd12: v = 6'h2D;
         5'd3, 5'd11: v = 6'h33;
         5'd4, 5'd10: v = 6'h38;
         5'd5, 5'd9: v = 6'h3C;
         5'd6, 5'd8: v = 6'h3E;
         5'd7: v = 6'h3F;
         5'd15, 5'd27: v = 6'h19;
         5'd16, 5'd26: v = 6'h13;
         5'd17, 5'd25: v = 6'h0D;
         5'd18, 5'd24: v = 6'h08;
         5'd19, 5'd23: v = 6'h04;
         5'd20, 5'd22: v = 6'h02;
         5'd21: v = 6'h01;
         default: v = SINE_MID;
      endcase
      return v;
   endfunction : sine_step

endpackage : dtmg_pkg
`default_nettype wire

// ---- dtmg_sine_rom.sv ----
// Two-port staircase sine table with registered read data
`timescale 1ns/10ps
`default_nettype none
module dtmg_sine_rom (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [dtmg_pkg::SCAN_W-1:0] row_idx,
   input wire logic [dtmg_pkg::SCAN_W-1:0] col_idx,
   output logic [dtmg_pkg::SAMPLE_W-1:0] row_data,
   output logic [dtmg_pkg::SAMPLE_W-1:0] col_data
);
   import dtmg_pkg::*;

   // Both paths read the same table; data lag the index by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         row_data <= SINE_MID;
         col_data <= SINE_MID;
      end else begin
         row_data <= sine_step(row_idx);
         col_data <= sine_step(col_idx);
      end
   end
endmodule : dtmg_sine_rom
`default_nettype wire

// ---- dtmg_tone_generator.sv ----
// Register-controlled dual tone and melody generator with AXI4-Lite access
//
// Function
// - Five-bit row and column codes, upper bits zero
// - Any illegal code blanks both tone samples, driver stays on
// - Illegal code: pacifier high, tone at mid
// - DTMF row and column codes set frequencies
// - Melody codes on either path set notes
// - Control: mode, path enables, output enable
// - Mode field picks sine or square mixing
// - Pacifier active only in modes 2, 3
// - Mode 3: column on tone, row on pacifier
// - Reset clears output enable, driver off
// - Both paths off: tone output at midpoint
// - Stop state: pacifier high, tone driver off
// - Both paths off: divider and scanner counters held reset
// - Enabled legal path starts from reset state
// - Scanner reset state selects dc midpoint entry
// - Divider pulses step a modulo-28 table scanner
// - Square modes keep only the table MSB
// - Pacifier taken from row MSB, unfiltered
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module dtmg_tone_generator (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stop_request,
   output logic [dtmg_pkg::SAMPLE_W-1:0] tone_row_sample,
   output logic [dtmg_pkg::SAMPLE_W-1:0] tone_col_sample,
   output logic tone_out_oe,
   output logic pacifier_pin
);
   import dtmg_pkg::*;

   // Whole state of the block in one record
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] aw_addr;
      logic [7:0] w_data;
      logic w_lane0;
      logic [4:0] row_sel;
      logic [4:0] col_sel;
      logic [7:0] ctrl;
      logic [PRE_W-1:0] pre;
      dtmg_path_t [1:0] path;
      logic [SAMPLE_W-1:0] row_sample;
      logic [SAMPLE_W-1:0] col_sample;
      logic tone_oe;
      logic pacifier;
   } dtmg_state_t;

   // Ready flags start high so the slave accepts at once after reset
   localparam dtmg_state_t STATE_RESET = '{
      awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
      arready: 1'b1, rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0000_0000,
      aw_addr: 8'h00, w_data: 8'h00, w_lane0: 1'b0,
      row_sel: SEL_RESET, col_sel: SEL_RESET, ctrl: CTRL_RESET,
      pre: '0, path: '0,
      row_sample: SINE_MID, col_sample: SINE_MID,
      tone_oe: 1'b0, pacifier: 1'b1};

   dtmg_state_t s; // Registered state
   dtmg_state_t next_s; // Next state
   logic [SAMPLE_W-1:0] rom_row; // Table word of the row path
   logic [SAMPLE_W-1:0] rom_col; // Table word of the column path
   logic code_illegal; // Either frequency code is illegal
   logic [1:0] run; // Path is counting
   logic [1:0] mode; // Wave mode field
   logic square; // Any square mode
   logic tick; // Half-rate base clock pulse

   // Table lookup; its output register sits in the memory module
   dtmg_sine_rom u_rom (
      .aclk(aclk),
      .aresetn(aresetn),
      .row_idx(s.path[ROW].scan),
      .col_idx(s.path[COL].scan),
      .row_data(rom_row),
      .col_data(rom_col)
   );

   // Decode of current control state
   always_comb begin
      mode = {s.ctrl[MODE_HI_BIT], s.ctrl[MODE_LO_BIT]};
      square = (mode != MODE_SINE);
      // Row list codes are illegal for column and the reverse
      code_illegal = (s.row_sel >= 5'h10 && s.row_sel <= 5'h13) ||
                     (s.col_sel <= 5'h03);
      // A path runs only with its enable, legal codes and no stop
      run[ROW] = s.ctrl[ROW_EN_BIT] && !code_illegal && !stop_request;
      run[COL] = s.ctrl[COL_EN_BIT] && !code_illegal && !stop_request;
      tick = (s.pre == PRE_W'(PRESCALE_CNT - 1));
   end

   // Next-state logic: bus slave, counters and output shaping
   always_comb begin
      next_s = s;
      // Write address channel
      if (s.awready && s_axi_awvalid) begin
         next_s.aw_addr = s_axi_awaddr;
         next_s.awready = 1'b0;
      end
      // Write data channel, taken in either order
      if (s.wready && s_axi_wvalid) begin
         next_s.w_data = s_axi_wdata[7:0];
         next_s.w_lane0 = s_axi_wstrb[0];
         next_s.wready = 1'b0;
      end
      // Both halves held: commit and answer
      if (!s.awready && !s.wready && !s.bvalid) begin
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         unique case ({s.aw_addr[7:2], 2'b00})
            ROW_SEL_ADDR: begin
               if (s.w_lane0) next_s.row_sel = s.w_data[4:0];
            end
            COL_SEL_ADDR: begin
               if (s.w_lane0) next_s.col_sel = s.w_data[4:0];
            end
            CTRL_ADDR: begin
               if (s.w_lane0) next_s.ctrl = s.w_data & CTRL_MASK;
            end
            STATUS_ADDR: begin
               // Status is read only; writes are dropped
               next_s.bresp = RESP_OKAY;
            end
            default: begin
               next_s.bresp = RESP_SLVERR;
            end
         endcase
      end
      // Response taken: reopen both write channels
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end
      // Read address: answer one cycle later with registered data
      if (s.arready && s_axi_arvalid) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         unique case ({s_axi_araddr[7:2], 2'b00})
            ROW_SEL_ADDR: next_s.rdata[4:0] = s.row_sel;
            COL_SEL_ADDR: next_s.rdata[4:0] = s.col_sel;
            CTRL_ADDR: next_s.rdata[7:0] = s.ctrl & CTRL_MASK;
            STATUS_ADDR: begin
               next_s.rdata[3:0] = {s.pacifier, run[COL], run[ROW],
                                    code_illegal};
            end
            default: next_s.rresp = RESP_SLVERR;
         endcase
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end

      // Half-rate base clock from the system clock
      next_s.pre = tick ? '0 : s.pre + 1'b1;

      // Divider steps the scanner; idle paths sit at their reset state
      for (int p = 0; p < 2; p++) begin
         if (!run[p]) begin
            next_s.path[p] = '0;
         end else if (tick) begin
            if (s.path[p].div ==
                tone_ratio(p == ROW ? s.row_sel : s.col_sel) - 1'b1) begin
               next_s.path[p].div = '0;
               next_s.path[p].scan = (s.path[p].scan == SCAN_LAST) ?
                  '0 : s.path[p].scan + 1'b1;
            end else begin
               next_s.path[p].div = s.path[p].div + 1'b1;
            end
         end
      end

      // Row sample: off, illegal or mode 3 gives the midpoint
      if (!run[ROW] || mode == MODE_SQUARE3) begin
         next_s.row_sample = SINE_MID;
      end else if (square) begin
         next_s.row_sample = {rom_row[SAMPLE_W-1], 5'h00};
      end else begin
         next_s.row_sample = rom_row;
      end
      // Column sample
      if (!run[COL]) begin
         next_s.col_sample = SINE_MID;
      end else if (square) begin
         next_s.col_sample = {rom_col[SAMPLE_W-1], 5'h00};
      end else begin
         next_s.col_sample = rom_col;
      end
      // Pacifier rests high outside modes 2 and 3 and when blanked
      if ((mode == MODE_SQUARE2 || mode == MODE_SQUARE3) && run[ROW]) begin
         next_s.pacifier = rom_row[SAMPLE_W-1];
      end else begin
         next_s.pacifier = 1'b1;
      end
      // Driver follows the enable, released in stop
      next_s.tone_oe = s.ctrl[OUT_EN_BIT] && !stop_request;
   end

   // Single state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rdata = s.rdata;
   assign tone_row_sample = s.row_sample;
   assign tone_col_sample = s.col_sample;
   assign tone_out_oe = s.tone_oe;
   assign pacifier_pin = s.pacifier;

   // Checks on the tone paths
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_illegal_blanks: assert property (code_illegal |=> pacifier_pin &&
      tone_row_sample == SINE_MID && tone_col_sample == SINE_MID)
      else $error("illegal code did not blank outputs");
   a_stop_quiet: assert property (stop_request |=>
      pacifier_pin && !tone_out_oe)
      else $error("stop did not quiet the outputs");
   a_oe_follows: assert property (!s.ctrl[OUT_EN_BIT] |=> !tone_out_oe)
      else $error("tone driver on without enable");
   a_idle_counters: assert property (
      (!s.ctrl[ROW_EN_BIT] && !s.ctrl[COL_EN_BIT]) |=>
      s.path[ROW] == '0 && s.path[COL] == '0)
      else $error("counters run with both paths off");
   a_start_reset: assert property ($rose(run[ROW]) |->
      s.path[ROW].div == '0 && s.path[ROW].scan == '0)
      else $error("row path did not start from reset");
   a_pacifier_rest: assert property (
      (mode == MODE_SINE || mode == MODE_SQUARE1) |=> pacifier_pin)
      else $error("pacifier moved outside modes 2 and 3");
   a_mode3_row: assert property ((mode == MODE_SQUARE3) |=>
      tone_row_sample == SINE_MID)
      else $error("row tone present in mode 3");
   a_square_mask: assert property (square |=>
      tone_row_sample[4:0] == 5'h00 && tone_col_sample[4:0] == 5'h00)
      else $error("square mode passed low table bits");
   a_scan_wrap: assert property ((tick && run[COL] &&
      s.path[COL].scan == SCAN_LAST && s.path[COL].div ==
      tone_ratio(s.col_sel) - 1'b1) |=> s.path[COL].scan == '0)
      else $error("column scanner did not wrap at 28");
   a_both_off_mid: assert property (
      (!run[ROW] && !run[COL]) ##1 (!run[ROW] && !run[COL]) |->
      tone_row_sample == SINE_MID && tone_col_sample == SINE_MID)
      else $error("tone content with both paths off");

   c_dual_tone: cover property (run[ROW] && run[COL] && mode == MODE_SINE);
   c_mode3: cover property (run[ROW] && run[COL] && mode == MODE_SQUARE3);
   c_illegal: cover property (code_illegal && s.ctrl[OUT_EN_BIT]);
   c_pac_low: cover property (mode == MODE_SQUARE2 && !pacifier_pin);
   // Pacifier copies the row table top bit, one cycle on
   a_pacifier_row: assert property (
      ((mode == MODE_SQUARE2 || mode == MODE_SQUARE3) && run[ROW]) |=>
      pacifier_pin == $past(rom_row[SAMPLE_W-1]))
      else $error("pacifier does not follow the row table bit");
   c_stop: cover property (stop_request && s.ctrl[OUT_EN_BIT]);
endmodule : dtmg_tone_generator
`default_nettype wire

// ---- tb_dtmg_tone_generator.sv ----
// Self-checking bench of the tone generator: bus, modes and pins
`timescale 1ns/10ps
`default_nettype none
module tb_dtmg_tone_generator;
   import dtmg_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   n_errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
   logic aclk; // 100 MHz system clock
   logic aresetn = 1'b0; // Held low for the first four cycles
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rv;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, stop = 1'b0, clr = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, oe, pac;
   logic [1:0] bresp, rresp, note_b;
   logic [33:0] note_r;
   logic [5:0] row_s, col_s, peak;
   logic [31:0] low_len, low_total, row_mv, col_mv, col_odd;
   logic [1:0] exp_b[$]; // Expected write responses, oldest first
   logic [33:0] exp_r[$]; // Expected {response, data} of reads
   int n_checks = 0;
   int n_errors = 0;
   int n;

   dtmg_tone_generator i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .stop_request(stop), .tone_row_sample(row_s),
      .tone_col_sample(col_s), .tone_out_oe(oe), .pacifier_pin(pac));

   dtmg_listener i_far (.aclk(aclk), .clear(clr), .row_sample(row_s),
      .col_sample(col_s), .pacifier(pac), .low_len(low_len),
      .low_total(low_total), .row_moves(row_mv), .col_moves(col_mv),
      .col_odd(col_odd), .col_peak(peak));

   // Free-running clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Answer watcher: every bus answer retires the oldest note
   always @(posedge aclk) begin
      if (bvalid && bready && exp_b.size() > 0) begin
         note_b = exp_b.pop_front();
         `CHK("write response", note_b, bresp)
      end
      if (rvalid && rready && exp_r.size() > 0) begin
         note_r = exp_r.pop_front();
         `CHK("read answer", note_r, {rresp, rdata})
      end
   end

   // Bus write: both channels offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] r);
      int k;
      @(posedge aclk);
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && k < 100);
      // A write that never answers counts against the run
      if (!bvalid) n_errors++;
      bready <= 1'b0;
   endtask : wr

   // Bus read; the watcher compares the answer with the note
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      int k;
      @(posedge aclk);
      exp_r.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && k < 100);
      // A read that never answers counts against the run
      if (!rvalid) n_errors++;
      rready <= 1'b0;
   endtask : rd

   task automatic tick(input int c);
      repeat (c) @(posedge aclk);
   endtask : tick

   // Restart the listener's counts from this cycle on
   task automatic listen();
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
   endtask : listen

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // Main sequence; where a step writes codes, they go in before its control word
   initial begin
      void'($urandom(32'h9204_9820));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      tick(2);
      `CHK("driver after reset", 1'b0, oe)
      `CHK("pacifier after reset", 1'b1, pac)
      rd(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
      $display("test reset done");
      rv = $urandom();
      wr(ROW_SEL_ADDR, rv[7:0], RESP_OKAY);
      rd(ROW_SEL_ADDR, {27'h000_0000, rv[4:0]}, RESP_OKAY);
      // Lane 0 strobe low: the write is answered but changes nothing
      wstrb <= 4'h0;
      wr(ROW_SEL_ADDR, ~rv[7:0], RESP_OKAY);
      rd(ROW_SEL_ADDR, {27'h000_0000, rv[4:0]}, RESP_OKAY);
      wstrb <= 4'hF;
      wr(COL_SEL_ADDR, rv[15:8], RESP_OKAY);
      rd(COL_SEL_ADDR, {27'h000_0000, rv[12:8]}, RESP_OKAY);
      wr(CTRL_ADDR, rv[23:16], RESP_OKAY);
      rd(CTRL_ADDR, {24'h00_0000, rv[23:19], 3'h0}, RESP_OKAY);
      wr(8'h00, rv[7:0], RESP_SLVERR);
      rd(8'h00, 32'h0000_0000, RESP_SLVERR);
      $display("test registers done");
      // Row code in the column register and the reverse
      for (int i = 0; i < 2; i++) begin
         wr(ROW_SEL_ADDR, i ? 8'h00 : 8'h10, RESP_OKAY);
         wr(COL_SEL_ADDR, i ? 8'h00 : 8'h10, RESP_OKAY);
         wr(CTRL_ADDR, 8'hB8, RESP_OKAY);
         listen();
         tick(5500);
         `CHK("pacifier on bad code", 1'b1, pac)
         `CHK("row moves on bad code", 32'h0000_0000, row_mv)
         `CHK("column moves on bad code", 32'h0000_0000, col_mv)
         `CHK("driver on bad code", 1'b1, oe)
         // Status: pacifier high, both paths stopped, code flagged
         rd(STATUS_ADDR, 32'h0000_0009, RESP_OKAY);
      end
      $display("test illegal codes done");
      wr(ROW_SEL_ADDR, 8'h1F, RESP_OKAY);
      wr(COL_SEL_ADDR, 8'h1F, RESP_OKAY);
      wr(CTRL_ADDR, 8'h08, RESP_OKAY);
      listen();
      tick(5500);
      `CHK("driver with paths off", 1'b1, oe)
      `CHK("row idle", 32'h0000_0000, row_mv)
      `CHK("column idle", 32'h0000_0000, col_mv)
      $display("test idle done");
      // Mode 3: column melody on tone, row square on the pacifier
      wr(CTRL_ADDR, 8'hF8, RESP_OKAY);
      listen();
      n = 0;
      while (low_len == 0 && n < 60000) begin
         @(posedge aclk);
         n++;
      end
      `CHK("pacifier low width", 13 * 27 * PRESCALE_CNT, low_len)
      `CHK("row sample in mode 3", 32'h0000_0000, row_mv)
      `CHK("column square", 32'h0000_0000, col_odd)
      `CHK("column active", 1'b1, col_mv > 0)
      stop <= 1'b1;
      tick(3);
      `CHK("driver in stop", 1'b0, oe)
      `CHK("pacifier in stop", 1'b1, pac)
      stop <= 1'b0;
      $display("test mode 3 done");
      // Mode 1: square on tone, pacifier stays high
      wr(CTRL_ADDR, 8'h78, RESP_OKAY);
      listen();
      tick(23000);
      `CHK("pacifier in mode 1", 32'h0000_0000, low_total)
      `CHK("column square mode 1", 32'h0000_0000, col_odd)
      `CHK("row active mode 1", 1'b1, row_mv > 0)
      $display("test mode 1 done");
      // Mode 0: sine column alone reaches the table peak
      // Both paths off first so the column scanner restarts at step 0;
      // otherwise the peak step may lie beyond the listening span
      wr(CTRL_ADDR, 8'h08, RESP_OKAY);
      wr(CTRL_ADDR, 8'h18, RESP_OKAY);
      listen();
      tick(13000);
      `CHK("sine peak", 6'h3F, peak)
      `CHK("row path off", 32'h0000_0000, row_mv)
      $display("test mode 0 done");
      test_done();
   end

   // Watchdog only a little past the whole expected run
   initial begin
      repeat (100000) @(posedge aclk);
      n_errors++;
      test_done();
   end
endmodule : tb_dtmg_tone_generator
`default_nettype wire
